// *** frj_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none

module frj_far_side (
  input  wire logic               core_clk,
  input  wire logic [4:0]         contact,
  input  wire logic               set_we,
  input  wire logic [3:0]         set_src,
  input  wire logic [15:0]        set_val,
  input  wire logic [3:0]         active_freq_source,
  output logic [4:0]              terminal_raw,
  output frj_pkg::frj_freq_t      freq_ref
);
  // ----------------------------------------------------------------
  // terminals and reference sources
  // ----------------------------------------------------------------
  // one reference value per source code; the drive reads the one it selected
  logic [15:0] ref_tbl_ff [0:8];
  logic [4:0]  raw_ff;

  initial begin
    for (int i = 0; i < 9; i++) begin
      ref_tbl_ff[i] = 16'h0000;
    end
    raw_ff = 5'h00;
  end

  // contacts reach the drive one clock late, as a synchronised level
  always @(posedge core_clk) begin
    raw_ff <= contact;
    if (set_we) begin
      ref_tbl_ff[set_src] <= set_val;
    end
  end

  assign terminal_raw = raw_ff;
  assign freq_ref     = ref_tbl_ff[active_freq_source];
endmodule

`default_nettype wire

// *** frj_input_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module frj_input_filter (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              ms_tick,
  input  wire logic              raw,
  input  wire frj_pkg::frj_ftime_t on_time,
  input  wire frj_pkg::frj_ftime_t off_time,
  output logic                   level
);

  frj_pkg::frj_filt_state_t st_ff;
  frj_pkg::frj_filt_state_t nxt_st;
  frj_pkg::frj_ftime_t      lim;

  assign lim   = raw ? on_time : off_time;
  assign level = st_ff.stable;

  // ----------------------------------------------------------------
  // persistence filter
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (raw == st_ff.stable) begin
      nxt_st.cnt = '0;
    end else if (lim == '0) begin
      nxt_st.stable = raw;
      nxt_st.cnt    = '0;
    end else if (ms_tick) begin
      // a glitch back to the stable level restarts the count
      if (st_ff.cnt + 14'h0001 >= lim) begin
        nxt_st.stable = raw;
        nxt_st.cnt    = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_zero_time_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
    (raw != level) && (lim == '0) |=> level == $past(raw))
    else $error("zero filter time did not pass level at once");

  a_change_on_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(level) |-> $past(ms_tick) || ($past(lim) == '0))
    else $error("filtered level changed without a tick");

  a_hold_on_match: assert property (@(posedge core_clk) disable iff (!rst_b)
    (raw == level) |=> $stable(level))
    else $error("filtered level moved while raw matched it");

endmodule

`default_nettype wire

// *** frj_map.svh ***
`ifndef FRJ_MAP_SVH
`define FRJ_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FRJ_OFS_CTRL        8'h00
`define FRJ_OFS_PRI_SRC     8'h04
`define FRJ_OFS_SEC_SRC     8'h08
`define FRJ_OFS_JUMP_BASE   8'h0C
`define FRJ_OFS_MAX_FREQ    8'h24
`define FRJ_OFS_FUNC_BASE   8'h28
`define FRJ_OFS_ON_FILT     8'h3C
`define FRJ_OFS_OFF_FILT    8'h40
`define FRJ_OFS_CONTACT     8'h44
`define FRJ_OFS_STATUS      8'h48
`define FRJ_OFS_FREQ_OUT    8'h4C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FRJ_CTRL_JUMP_EN    0
`define FRJ_CTRL_RUN_NO     1
`define FRJ_SRC_FREQ_LSB    4
`define FRJ_STAT_SEL        8

// ----------------------------------------------------------------
// reset values and limits (frequencies in 0.01 Hz)
// ----------------------------------------------------------------
`define FRJ_RST_PRI_CMD     3'h1
`define FRJ_RST_PRI_FREQ    4'h2
`define FRJ_RST_SEC_CMD     3'h0
`define FRJ_RST_SEC_FREQ    4'h0
`define FRJ_RST_JUMP_LO0    16'h03E8
`define FRJ_RST_JUMP_HI0    16'h05DC
`define FRJ_RST_JUMP_LO1    16'h07D0
`define FRJ_RST_JUMP_HI1    16'h09C4
`define FRJ_RST_JUMP_LO2    16'h0BB8
`define FRJ_RST_JUMP_HI2    16'h0DAC
`define FRJ_RST_MAX_FREQ    16'h1770
`define FRJ_MAX_FREQ_MIN    16'h0FA0
`define FRJ_MAX_FREQ_TOP    16'h9C40
`define FRJ_CMD_SRC_TOP     3'h4
`define FRJ_FREQ_SRC_TOP    4'h8
`define FRJ_FUNC_TOP        6'h34
`define FRJ_FUNC_SEC_SRC    6'h0F
`define FRJ_FUNC_FWD_RUN    6'h01
`define FRJ_FUNC_REV_RUN    6'h02

// ----------------------------------------------------------------
// filter times in millisecond ticks
// ----------------------------------------------------------------
`define FRJ_RST_ON_FILT     14'h000A
`define FRJ_RST_OFF_FILT    14'h0003
`define FRJ_FILT_TOP        14'h2710

`endif

// *** frj_pkg.sv ***
package frj_pkg;

  typedef logic [15:0] frj_freq_t;
  typedef logic [13:0] frj_ftime_t;
  typedef logic [5:0]  frj_func_t;

  typedef struct packed {
    logic       stable;
    frj_ftime_t cnt;
  } frj_filt_state_t;

endpackage

// *** frj_ref_cond.sv ***
// What this block does
// - with jumping on and no bands overlapping, output frequency never rests strictly inside a band
// - rising reference inside a band holds output at the band's lower edge
// - rising reference above a band's upper edge is followed again
// - skipping acts on both accelerating and decelerating ramps
// - one-bit jump enable, 0 off, 1 on, off after reset
// - three jump bands, defaults 10-15, 20-25, 30-35 Hz
// - lower edge 0..upper edge; upper edge lower edge..maximum frequency
// - terminal function code 15 marks the source selector terminal
// - selector active: run command and reference come from secondary settings
// - secondary source writes refused while running under main source
// - command source 0..4, frequency source 0..8; defaults 1,2 and 0,0
// - five terminals each hold a function code 0..52
// - on and off filter times 0..10000 ms, defaults 10 and 3
// - one-bit setting choosing contact types allowed for run terminals
// - setting 1 forces run terminals normally open; 0 allows normally closed
`timescale 1ns/1ps
`default_nettype none
`include "frj_map.svh"

module frj_ref_cond #(
  parameter int N_TERM = 5,
  parameter int N_BAND = 3
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              ms_tick,
  input  wire logic [N_TERM-1:0] terminal_raw,
  input  wire logic              running,
  input  wire frj_pkg::frj_freq_t freq_ref,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic [N_TERM-1:0]      input_terminal_levels,
  output logic                   secondary_source_select,
  output logic [2:0]             active_cmd_source,
  output logic [3:0]             active_freq_source,
  output frj_pkg::frj_freq_t     freq_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (N_TERM < 1 || N_TERM > 5) begin : g_bad_term
    $error("N_TERM must lie in 1..5");
  end
  if (N_BAND != 3) begin : g_bad_band
    $error("N_BAND must be 3");
  end

  typedef struct packed {
    logic                                   jump_en;
    logic                                   run_no_only;
    logic [2:0]                             pri_cmd;
    logic [3:0]                             pri_freq;
    logic [2:0]                             sec_cmd;
    logic [3:0]                             sec_freq;
    logic [N_BAND-1:0][15:0]                jump_lo;
    logic [N_BAND-1:0][15:0]                jump_hi;
    logic [15:0]                            max_freq;
    logic [N_TERM-1:0][5:0]                 func;
    logic [13:0]                            on_filt;
    logic [13:0]                            off_filt;
    logic [N_TERM-1:0]                      nc_sel;
    logic [15:0]                            out;
    logic [31:0]                            rdata;
  } frj_state_t;

  frj_state_t        st_ff;
  frj_state_t        nxt_st;
  logic [N_TERM-1:0] filt_level;
  logic [N_TERM-1:0] active;
  logic              sel;
  logic [15:0]       cand;
  logic              max_ok;
  logic              sec_lock;

  // ----------------------------------------------------------------
  // terminal filters and contact handling
  // ----------------------------------------------------------------
  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    logic is_run;
    frj_input_filter u_filt (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ms_tick  (ms_tick),
      .raw      (terminal_raw[t]),
      .on_time  (st_ff.on_filt),
      .off_time (st_ff.off_filt),
      .level    (filt_level[t])
    );
    assign is_run    = (st_ff.func[t] == `FRJ_FUNC_FWD_RUN) || (st_ff.func[t] == `FRJ_FUNC_REV_RUN);
    // normally closed inverts, unless run terminals are forced open
    assign active[t] = filt_level[t] ^ (st_ff.nc_sel[t] & ~(st_ff.run_no_only & is_run));
  end

  always_comb begin
    sel = 1'b0;
    for (int t = 0; t < N_TERM; t++) begin
      if (active[t] && st_ff.func[t] == `FRJ_FUNC_SEC_SRC) begin
        sel = 1'b1;
      end
    end
  end

  assign sec_lock = running && !sel;

  // ----------------------------------------------------------------
  // jump band skipping
  // ----------------------------------------------------------------
  // bands are walked in order; overlapping bands are not merged
  always_comb begin
    cand = freq_ref;
    if (st_ff.jump_en) begin
      for (int b = 0; b < N_BAND; b++) begin
        if (cand > st_ff.jump_lo[b] && cand < st_ff.jump_hi[b]) begin
          // direction is inferred from where the output sat last
          cand = (st_ff.out >= st_ff.jump_hi[b]) ? st_ff.jump_hi[b] : st_ff.jump_lo[b];
        end
      end
    end
  end

  always_comb begin
    max_ok = (reg_wdata[15:0] >= `FRJ_MAX_FREQ_MIN) && (reg_wdata[15:0] <= `FRJ_MAX_FREQ_TOP);
    for (int b = 0; b < N_BAND; b++) begin
      if (reg_wdata[15:0] < st_ff.jump_hi[b]) begin
        max_ok = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.out   = cand;
    nxt_st.rdata = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        `FRJ_OFS_CTRL: begin
          nxt_st.jump_en     = reg_wdata[`FRJ_CTRL_JUMP_EN];
          nxt_st.run_no_only = reg_wdata[`FRJ_CTRL_RUN_NO];
        end
        `FRJ_OFS_PRI_SRC: begin
          if (reg_wdata[2:0] <= `FRJ_CMD_SRC_TOP && reg_wdata[7:4] <= `FRJ_FREQ_SRC_TOP) begin
            nxt_st.pri_cmd  = reg_wdata[2:0];
            nxt_st.pri_freq = reg_wdata[7:4];
          end
        end
        `FRJ_OFS_SEC_SRC: begin
          if (!sec_lock && reg_wdata[2:0] <= `FRJ_CMD_SRC_TOP && reg_wdata[7:4] <= `FRJ_FREQ_SRC_TOP) begin
            nxt_st.sec_cmd  = reg_wdata[2:0];
            nxt_st.sec_freq = reg_wdata[7:4];
          end
        end
        `FRJ_OFS_MAX_FREQ: begin
          if (max_ok) begin
            nxt_st.max_freq = reg_wdata[15:0];
          end
        end
        `FRJ_OFS_ON_FILT: begin
          if (reg_wdata[13:0] <= `FRJ_FILT_TOP && reg_wdata[31:14] == '0) begin
            nxt_st.on_filt = reg_wdata[13:0];
          end
        end
        `FRJ_OFS_OFF_FILT: begin
          if (reg_wdata[13:0] <= `FRJ_FILT_TOP && reg_wdata[31:14] == '0) begin
            nxt_st.off_filt = reg_wdata[13:0];
          end
        end
        `FRJ_OFS_CONTACT: begin
          nxt_st.nc_sel = reg_wdata[N_TERM-1:0];
        end
        default: begin
          for (int b = 0; b < N_BAND; b++) begin
            if (reg_addr == `FRJ_OFS_JUMP_BASE + 8'(8 * b) && reg_wdata[15:0] <= st_ff.jump_hi[b]) begin
              nxt_st.jump_lo[b] = reg_wdata[15:0];
            end
            if (reg_addr == `FRJ_OFS_JUMP_BASE + 8'(8 * b + 4) && reg_wdata[15:0] >= st_ff.jump_lo[b]
                && reg_wdata[15:0] <= st_ff.max_freq) begin
              nxt_st.jump_hi[b] = reg_wdata[15:0];
            end
          end
          for (int t = 0; t < N_TERM; t++) begin
            if (reg_addr == `FRJ_OFS_FUNC_BASE + 8'(4 * t) && reg_wdata[5:0] <= `FRJ_FUNC_TOP
                && reg_wdata[31:6] == '0) begin
              nxt_st.func[t] = reg_wdata[5:0];
            end
          end
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `FRJ_OFS_CTRL:     nxt_st.rdata = {30'h0, st_ff.run_no_only, st_ff.jump_en};
        `FRJ_OFS_PRI_SRC:  nxt_st.rdata = {24'h0, st_ff.pri_freq, 1'b0, st_ff.pri_cmd};
        `FRJ_OFS_SEC_SRC:  nxt_st.rdata = {24'h0, st_ff.sec_freq, 1'b0, st_ff.sec_cmd};
        `FRJ_OFS_MAX_FREQ: nxt_st.rdata = {16'h0, st_ff.max_freq};
        `FRJ_OFS_ON_FILT:  nxt_st.rdata = {18'h0, st_ff.on_filt};
        `FRJ_OFS_OFF_FILT: nxt_st.rdata = {18'h0, st_ff.off_filt};
        `FRJ_OFS_CONTACT:  nxt_st.rdata = 32'(st_ff.nc_sel);
        `FRJ_OFS_STATUS:   nxt_st.rdata = 32'(active) | (32'(sel) << `FRJ_STAT_SEL);
        `FRJ_OFS_FREQ_OUT: nxt_st.rdata = {16'h0, st_ff.out};
        default: begin
          for (int b = 0; b < N_BAND; b++) begin
            if (reg_addr == `FRJ_OFS_JUMP_BASE + 8'(8 * b)) begin
              nxt_st.rdata = {16'h0, st_ff.jump_lo[b]};
            end
            if (reg_addr == `FRJ_OFS_JUMP_BASE + 8'(8 * b + 4)) begin
              nxt_st.rdata = {16'h0, st_ff.jump_hi[b]};
            end
          end
          for (int t = 0; t < N_TERM; t++) begin
            if (reg_addr == `FRJ_OFS_FUNC_BASE + 8'(4 * t)) begin
              nxt_st.rdata = {26'h0, st_ff.func[t]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff             <= '0;
      st_ff.pri_cmd     <= `FRJ_RST_PRI_CMD;
      st_ff.pri_freq    <= `FRJ_RST_PRI_FREQ;
      st_ff.sec_cmd     <= `FRJ_RST_SEC_CMD;
      st_ff.sec_freq    <= `FRJ_RST_SEC_FREQ;
      st_ff.jump_lo[0]  <= `FRJ_RST_JUMP_LO0;
      st_ff.jump_hi[0]  <= `FRJ_RST_JUMP_HI0;
      st_ff.jump_lo[1]  <= `FRJ_RST_JUMP_LO1;
      st_ff.jump_hi[1]  <= `FRJ_RST_JUMP_HI1;
      st_ff.jump_lo[2]  <= `FRJ_RST_JUMP_LO2;
      st_ff.jump_hi[2]  <= `FRJ_RST_JUMP_HI2;
      st_ff.max_freq    <= `FRJ_RST_MAX_FREQ;
      st_ff.on_filt     <= `FRJ_RST_ON_FILT;
      st_ff.off_filt    <= `FRJ_RST_OFF_FILT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata               = st_ff.rdata;
  assign input_terminal_levels   = active;
  assign secondary_source_select = sel;
  assign active_cmd_source       = sel ? st_ff.sec_cmd : st_ff.pri_cmd;
  assign active_freq_source      = sel ? st_ff.sec_freq : st_ff.pri_freq;
  assign freq_out                = st_ff.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sec_write_locked;
    reg_wr && reg_addr == `FRJ_OFS_SEC_SRC && sec_lock;
  endsequence

  sequence s_rise_into_band0;
    st_ff.jump_en && freq_ref > st_ff.jump_lo[0] && freq_ref < st_ff.jump_hi[0]
      && st_ff.out <= st_ff.jump_lo[0] && freq_ref < st_ff.jump_lo[1];
  endsequence

  a_sec_write_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_sec_write_locked |=> $stable(st_ff.sec_cmd) && $stable(st_ff.sec_freq))
    else $error("secondary source written while locked");

  a_rise_hold_lo: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_rise_into_band0 ##0 !reg_wr |=> freq_out == $past(st_ff.jump_lo[0]))
    else $error("rising reference not held at lower edge");

  a_fall_hold_hi: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_ff.jump_en && !reg_wr && freq_ref > st_ff.jump_lo[2] && freq_ref < st_ff.jump_hi[2]
      && st_ff.out >= st_ff.jump_hi[2] |=> freq_out == $past(st_ff.jump_hi[2]))
    else $error("falling reference not held at upper edge");

  a_band_not_inside: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_ff.jump_en && !reg_wr && st_ff.jump_hi[0] <= st_ff.jump_lo[1] && st_ff.jump_hi[1] <= st_ff.jump_lo[2]
      |=> !(freq_out > st_ff.jump_lo[0] && freq_out < st_ff.jump_hi[0])
       && !(freq_out > st_ff.jump_lo[1] && freq_out < st_ff.jump_hi[1])
       && !(freq_out > st_ff.jump_lo[2] && freq_out < st_ff.jump_hi[2]))
    else $error("output rests inside a jump band");

  a_pass_above: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_ff.jump_en && freq_ref >= st_ff.jump_hi[2] |=> freq_out == $past(freq_ref))
    else $error("reference above bands not followed");

  a_jump_off_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    !st_ff.jump_en |=> freq_out == $past(freq_ref))
    else $error("output differs from reference with jumping off");

  a_src_select: assert property (@(posedge core_clk) disable iff (!rst_b)
    sel |-> active_cmd_source == st_ff.sec_cmd && active_freq_source == st_ff.sec_freq)
    else $error("secondary sources not used while selected");

  a_ranges_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_ff.pri_cmd <= `FRJ_CMD_SRC_TOP && st_ff.sec_freq <= `FRJ_FREQ_SRC_TOP
      && st_ff.on_filt <= `FRJ_FILT_TOP && st_ff.off_filt <= `FRJ_FILT_TOP)
    else $error("setting out of range");

  a_edges_ordered: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_ff.jump_lo[1] <= st_ff.jump_hi[1] && st_ff.jump_hi[1] <= st_ff.max_freq)
    else $error("band edges out of order");

  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");

endmodule

`default_nettype wire

// *** frj_ref_cond_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "frj_map.svh"

module frj_ref_cond_tb;
  logic               core_clk;
  logic               rst_b;
  logic               ms_tick;
  logic               running;
  logic               reg_wr;
  logic               reg_rd;
  logic               set_we;
  logic               secondary_source_select;
  logic [4:0]         contact;
  logic [4:0]         terminal_raw;
  logic [4:0]         input_terminal_levels;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic [31:0]        reg_rdata;
  logic [31:0]        rd_data;
  logic [3:0]         set_src;
  logic [3:0]         active_freq_source;
  logic [2:0]         active_cmd_source;
  logic [15:0]        set_val;
  frj_pkg::frj_freq_t freq_ref;
  frj_pkg::frj_freq_t freq_out;
  int                 miscompares;
  int                 samples_checked;
  int                 cycles;

  frj_ref_cond #(.N_TERM(5), .N_BAND(3)) i_frj_ref_cond (
    .core_clk(core_clk), .rst_b(rst_b), .ms_tick(ms_tick), .terminal_raw(terminal_raw),
    .running(running), .freq_ref(freq_ref), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_terminal_levels(input_terminal_levels), .secondary_source_select(secondary_source_select),
    .active_cmd_source(active_cmd_source), .active_freq_source(active_freq_source), .freq_out(freq_out)
  );

  frj_far_side i_frj_far_side (
    .core_clk(core_clk), .contact(contact), .set_we(set_we), .set_src(set_src), .set_val(set_val),
    .active_freq_source(active_freq_source), .terminal_raw(terminal_raw), .freq_ref(freq_ref)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the read strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk_val(reg_rdata, exp);
  endtask

  task automatic set_tbl(input logic [3:0] s, input logic [15:0] v);
    @(posedge core_clk);
    set_we  <= 1'b1;
    set_src <= s;
    set_val <= v;
    @(posedge core_clk);
    set_we <= 1'b0;
  endtask

  task automatic ref_chk(input logic [15:0] v, input logic [15:0] exp);
    set_tbl(active_freq_source, v);
    repeat (3) @(posedge core_clk);
    #1;
    chk_val({16'h0000, freq_out}, {16'h0000, exp});
  endtask

  task automatic tick;
    @(posedge core_clk);
    ms_tick <= 1'b1;
    @(posedge core_clk);
    ms_tick <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] edges [6];
    edges = '{16'h03E8, 16'h05DC, 16'h07D0, 16'h09C4, 16'h0BB8, 16'h0DAC};
    #1;
    chk_val({29'h0, active_cmd_source}, 32'h1);
    chk_val({28'h0, active_freq_source}, 32'h2);
    rd_chk(`FRJ_OFS_CTRL, 32'h0);
    rd_chk(`FRJ_OFS_PRI_SRC, 32'h21);
    rd_chk(`FRJ_OFS_SEC_SRC, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(`FRJ_OFS_JUMP_BASE + 4 * i), {16'h0000, edges[i]});
    end
    rd_chk(`FRJ_OFS_ON_FILT, 32'h0A);
    rd_chk(`FRJ_OFS_OFF_FILT, 32'h03);
    rd_chk(8'hFC, 32'h0);
  endtask

  task automatic t_jump;
    logic [15:0] refs [10];
    logic [15:0] exps [10];
    // last two steps climb past the top band, then fall back into it
    refs = '{16'h04B0, 16'h0384, 16'h04B0, 16'h03E8, 16'h0640, 16'h04B0, 16'h0384, 16'h0C80, 16'h0E10, 16'h0C80};
    exps = '{16'h04B0, 16'h0384, 16'h03E8, 16'h03E8, 16'h0640, 16'h05DC, 16'h0384, 16'h0BB8, 16'h0E10, 16'h0DAC};
    for (int i = 0; i < 10; i++) begin
      if (i == 1) begin
        wr(`FRJ_OFS_CTRL, 32'h1);
      end
      ref_chk(refs[i], exps[i]);
    end
    rd_chk(`FRJ_OFS_FREQ_OUT, 32'h0DAC);
  endtask

  task automatic t_limits;
    wr(`FRJ_OFS_JUMP_BASE, 32'h05DD);
    rd_chk(`FRJ_OFS_JUMP_BASE, 32'h03E8);
    wr(8'h10, 32'h1771);
    rd_chk(8'h10, 32'h05DC);
    wr(8'h20, 32'h1770);
    rd_chk(8'h20, 32'h1770);
    wr(`FRJ_OFS_MAX_FREQ, 32'h176F);
    rd_chk(`FRJ_OFS_MAX_FREQ, 32'h1770);
    wr(`FRJ_OFS_MAX_FREQ, 32'h9C40);
    rd_chk(`FRJ_OFS_MAX_FREQ, 32'h9C40);
    wr(`FRJ_OFS_PRI_SRC, 32'h05);
    rd_chk(`FRJ_OFS_PRI_SRC, 32'h21);
    wr(`FRJ_OFS_PRI_SRC, 32'h84);
    rd_chk(`FRJ_OFS_PRI_SRC, 32'h84);
    wr(`FRJ_OFS_PRI_SRC, 32'h21);
    wr(`FRJ_OFS_FUNC_BASE, 32'h35);
    rd_chk(`FRJ_OFS_FUNC_BASE, 32'h0);
    wr(`FRJ_OFS_FUNC_BASE, 32'h34);
    rd_chk(`FRJ_OFS_FUNC_BASE, 32'h34);
    wr(`FRJ_OFS_ON_FILT, 32'h2711);
    rd_chk(`FRJ_OFS_ON_FILT, 32'h0A);
    wr(`FRJ_OFS_ON_FILT, 32'h2710);
    rd_chk(`FRJ_OFS_ON_FILT, 32'h2710);
  endtask

  task automatic t_select;
    wr(`FRJ_OFS_ON_FILT, 32'h2);
    wr(`FRJ_OFS_OFF_FILT, 32'h0);
    wr(`FRJ_OFS_FUNC_BASE, 32'h0F);
    set_tbl(4'h5, 16'h1234);
    running <= 1'b1;
    wr(`FRJ_OFS_SEC_SRC, 32'h53);
    rd_chk(`FRJ_OFS_SEC_SRC, 32'h0);
    @(posedge core_clk);
    running <= 1'b0;
    wr(`FRJ_OFS_SEC_SRC, 32'h53);
    rd_chk(`FRJ_OFS_SEC_SRC, 32'h53);
    @(posedge core_clk);
    running <= 1'b1;
    contact <= 5'h01;
    repeat (3) @(posedge core_clk);
    tick();
    #1;
    chk_val({27'h0, input_terminal_levels}, 32'h0);
    tick();
    repeat (2) @(posedge core_clk);
    #1;
    chk_val({27'h0, input_terminal_levels}, 32'h1);
    chk_val({24'h0, active_freq_source, 1'b0, active_cmd_source}, 32'h53);
    chk_val({31'h0, secondary_source_select}, 32'h1);
    chk_val({16'h0, freq_ref}, 32'h1234);
    @(posedge core_clk);
    contact <= 5'h00;
    repeat (3) @(posedge core_clk);
    #1;
    chk_val({31'h0, secondary_source_select}, 32'h0);
    chk_val({29'h0, active_cmd_source}, 32'h1);
  endtask

  task automatic t_contact;
    wr(8'(`FRJ_OFS_FUNC_BASE + 4), 32'h01);
    wr(`FRJ_OFS_CONTACT, 32'h02);
    repeat (2) @(posedge core_clk);
    #1;
    chk_val({27'h0, input_terminal_levels}, 32'h02);
    wr(`FRJ_OFS_CTRL, 32'h3);
    wr(`FRJ_OFS_CONTACT, 32'h03);
    repeat (2) @(posedge core_clk);
    #1;
    chk_val({27'h0, input_terminal_levels}, 32'h01);
    rd_chk(`FRJ_OFS_STATUS, 32'h101);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // the whole run needs under two hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    miscompares     = 0;
    samples_checked = 0;
    cycles          = 0;
    rst_b           = 1'b0;
    ms_tick         = 1'b0;
    running         = 1'b0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0;
    set_we          = 1'b0;
    set_src         = 4'h0;
    set_val         = 16'h0;
    contact         = 5'h00;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_jump();
    t_limits();
    t_select();
    t_contact();
    end_of_test();
  end
endmodule

`default_nettype wire
